/* File: sip_consts.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 32-bit apb data, register index times four is the byte address
// Notes:   definitions only
`ifndef SIP_CONSTS_SVH
`define SIP_CONSTS_SVH

// register indices, byte address is index * 4
`define SIP_IDX_PTYPE  14'h1847
`define SIP_IDX_BCAST  14'h1848
`define SIP_IDX_ADMIT  14'h1849
`define SIP_IDX_MCFG   14'h184a
`define SIP_IDX_CMD    14'h184b
`define SIP_IDX_STS    14'h184c
`define SIP_IDX_WDATA  14'h184d
`define SIP_IDX_RDATA  14'h184e

// broadcast limit layout, one nine-bit slice per port
`define SIP_BC_STRIDE  9
`define SIP_BC_EN_OFS  8
`define SIP_BC_RST     27'h0080402
`define SIP_BC_BYTE_SH 6

// command register fields
`define SIP_CMD_DIR    7
`define SIP_CMD_TYP_HI 6
`define SIP_CMD_TYP_LO 5
`define SIP_CMD_ADR_HI 4

// meter config fields
`define SIP_MCFG_EN    0
`define SIP_MCFG_MD_HI 2
`define SIP_MCFG_MD_LO 1

// metering table
`define SIP_CIR_NUM    24
`define SIP_CIR_RST    16'h0014
`define SIP_BURST_RST  16'h0600
`define SIP_PRI_PER_PT 8

// command latency in clock cycles
`define SIP_OP_CYC     2'd2

// broadcast interval, clock period in ns
`define SIP_THROT_NS   1720000
`define SIP_CLK_NS     10
`define SIP_THROT_CYC  (`SIP_THROT_NS / `SIP_CLK_NS)

`endif

/* File: sip_pkg.sv */
// Purpose: types shared by the ingress policy register bank
// Assumes: sip_consts.svh on the include path
// Notes:   state of the bank is one packed struct
`include "sip_consts.svh"
package sip_pkg;
  typedef enum logic {SIP_IDLE, SIP_BUSY} sip_op_t;
  typedef enum logic [1:0] {SIP_M_PORT_PRI, SIP_M_PORT, SIP_M_PRI, SIP_M_RSVD} sip_mode_t;
  typedef enum logic [1:0] {SIP_T_RSVD, SIP_T_CIR, SIP_T_CBS, SIP_T_EBS} sip_tbl_t;

  typedef struct packed {
    logic [5:0]        port_type;
    logic [26:0]       bcast;
    logic [2:0]        admit;
    logic [2:0]        mcfg;
    logic [7:0]        cmd;
    logic [15:0]       wdata;
    logic [15:0]       rdata;
    sip_op_t           op;
    logic [1:0]        op_cnt;
    logic [23:0][15:0] committed_rate_entry;
    logic [15:0]       cbs;
    logic [15:0]       ebs;
    logic [17:0]       timer;
    logic [2:0][13:0]  used;
    logic [2:0]        allow;
    logic [31:0]       prdata;
    logic              vlan_acc;
    logic              meter_on;
    logic [15:0]       mtr_cir;
  } sip_state_t;
endpackage

/* File: sip_regs.sv */
// Purpose: ingress policy registers of a three-port switch engine
// Assumes: apb slave with zero wait states, inputs synchronous to CORE_CLK
// Notes:   metering table reached indirectly through command register
`timescale 1ns/1ps
module sip_regs
  import sip_pkg::*;
#(
  parameter int THROT_CYC = `SIP_THROT_CYC
) (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        NRST,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [15:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // tag-directed destination per port
  output logic      [2:0]  TAG_DEST_EN,
  // broadcast throttling, one byte pulse per port
  input  wire logic [2:0]  BCAST_BYTE,
  output logic      [2:0]  BCAST_ALLOW,
  // vlan admission check
  input  wire logic [1:0]  VLAN_CHECK_PORT,
  input  wire logic        VLAN_PORT_MEMBER,
  input  wire logic        VLAN_ACTIVE,
  output logic             VLAN_ACCEPT,
  // metering lookup
  input  wire logic [1:0]  MTR_PORT,
  input  wire logic [4:0]  MTR_PRIO,
  output logic             METER_ON,
  output logic      [1:0]  METER_MODE,
  output logic      [15:0] MTR_CIR,
  output logic      [15:0] MTR_CBS,
  output logic      [15:0] MTR_EBS
);

  sip_state_t s_r;
  sip_state_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte address of a register index
  function automatic logic [15:0] waddr(input logic [13:0] idx);
    return {idx, 2'b00};
  endfunction

  // rate entry at an index; out of range gives zero
  function automatic logic [15:0] cir_at(input logic [23:0][15:0] t, input logic [4:0] a);
    return (a < 5'(`SIP_CIR_NUM)) ? t[a] : 16'h0000;
  endfunction

  // entry used by a packet for the active mode
  // port and priority mode keeps only the low three priority bits
  function automatic logic [4:0] meter_idx(input sip_mode_t m, input logic [1:0] p,
                                           input logic [4:0] pr);
    unique case (m)
      SIP_M_PORT_PRI: return {p, pr[2:0]};
      SIP_M_PORT:     return {3'h0, p};
      SIP_M_PRI:      return pr;
      SIP_M_RSVD:     return 5'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic       wr_acc;
  logic       setup;
  logic       hit;
  logic       cmd_wr;
  logic       tick;
  logic [4:0] t_adr;
  sip_tbl_t   t_typ;
  sip_mode_t  mode;

  always_comb begin
    s_nxt  = s_r;
    wr_acc = PSEL & PENABLE & PWRITE;
    setup  = PSEL & ~PENABLE;
    hit    = 1'b1;
    mode   = sip_mode_t'(s_r.mcfg[`SIP_MCFG_MD_HI:`SIP_MCFG_MD_LO]);
    t_typ  = sip_tbl_t'(s_r.cmd[`SIP_CMD_TYP_HI:`SIP_CMD_TYP_LO]);
    t_adr  = s_r.cmd[`SIP_CMD_ADR_HI:0];
    cmd_wr = wr_acc & (PADDR == waddr(`SIP_IDX_CMD));

    // read data is caught in the setup cycle so PRDATA comes from a flop
    if (setup) begin
      unique case (PADDR)
        waddr(`SIP_IDX_PTYPE): s_nxt.prdata = {26'h0, s_r.port_type};
        waddr(`SIP_IDX_BCAST): s_nxt.prdata = {5'h00, s_r.bcast};
        waddr(`SIP_IDX_ADMIT): s_nxt.prdata = {29'h0, s_r.admit};
        waddr(`SIP_IDX_MCFG):  s_nxt.prdata = {29'h0, s_r.mcfg};
        waddr(`SIP_IDX_CMD):   s_nxt.prdata = {24'h0, s_r.cmd};
        waddr(`SIP_IDX_STS):   s_nxt.prdata = {31'h0, s_r.op == SIP_BUSY};
        waddr(`SIP_IDX_WDATA): s_nxt.prdata = {16'h0, s_r.wdata};
        waddr(`SIP_IDX_RDATA): s_nxt.prdata = {16'h0, s_r.rdata};
        default:               s_nxt.prdata = 32'h0;
      endcase
    end
    // any address outside the eight registers answers with a slave error
    if (PADDR != waddr(`SIP_IDX_PTYPE) && PADDR != waddr(`SIP_IDX_BCAST) &&
        PADDR != waddr(`SIP_IDX_ADMIT) && PADDR != waddr(`SIP_IDX_MCFG) &&
        PADDR != waddr(`SIP_IDX_CMD) && PADDR != waddr(`SIP_IDX_STS) &&
        PADDR != waddr(`SIP_IDX_WDATA) && PADDR != waddr(`SIP_IDX_RDATA))
      hit = 1'b0;

    // plain register writes; status and read data are read-only
    if (wr_acc) begin
      if (PADDR == waddr(`SIP_IDX_PTYPE)) s_nxt.port_type = PWDATA[5:0];
      if (PADDR == waddr(`SIP_IDX_BCAST)) s_nxt.bcast = PWDATA[26:0];
      if (PADDR == waddr(`SIP_IDX_ADMIT)) s_nxt.admit = PWDATA[2:0];
      if (PADDR == waddr(`SIP_IDX_MCFG))  s_nxt.mcfg = PWDATA[2:0];
      if (PADDR == waddr(`SIP_IDX_WDATA)) s_nxt.wdata = PWDATA[15:0];
    end

    // table command engine; a command written while busy is dropped whole
    // write data is taken at completion, so it must be loaded before the command
    unique case (s_r.op)
      SIP_IDLE: begin
        if (cmd_wr) begin
          s_nxt.cmd    = PWDATA[7:0];
          s_nxt.op     = SIP_BUSY;
          s_nxt.op_cnt = `SIP_OP_CYC - 2'd1;
        end
      end
      SIP_BUSY: begin
        if (s_r.op_cnt != 2'd0) begin
          s_nxt.op_cnt = s_r.op_cnt - 2'd1;
        end else begin
          s_nxt.op = SIP_IDLE;
          if (s_r.cmd[`SIP_CMD_DIR]) begin
            unique case (t_typ)
              SIP_T_CIR:  s_nxt.rdata = cir_at(s_r.committed_rate_entry, t_adr);
              SIP_T_CBS:  s_nxt.rdata = s_r.cbs;
              SIP_T_EBS:  s_nxt.rdata = s_r.ebs;
              SIP_T_RSVD: s_nxt.rdata = 16'h0000;
            endcase
          end else begin
            unique case (t_typ)
              SIP_T_CIR: begin
                if (t_adr < 5'(`SIP_CIR_NUM))
                  s_nxt.committed_rate_entry[t_adr] = s_r.wdata;
              end
              SIP_T_CBS:  s_nxt.cbs = s_r.wdata;
              SIP_T_EBS:  s_nxt.ebs = s_r.wdata;
              SIP_T_RSVD: s_nxt.cbs = s_r.cbs;
            endcase
          end
        end
      end
    endcase

    // broadcast budget per port, refilled every interval
    // a pulse in the refill cycle is not charged: one byte of slack buys a simpler counter
    tick        = (s_r.timer == 18'(THROT_CYC - 1));
    s_nxt.timer = tick ? 18'h0 : s_r.timer + 18'h1;
    for (int p = 0; p < 3; p++) begin
      if (tick)
        s_nxt.used[p] = 14'h0;
      else if (BCAST_BYTE[p] && s_r.used[p] != 14'h3fff)
        s_nxt.used[p] = s_r.used[p] + 14'h1;
      s_nxt.allow[p] = ~s_r.bcast[p*`SIP_BC_STRIDE + `SIP_BC_EN_OFS] |
                       (s_nxt.used[p] < {s_r.bcast[p*`SIP_BC_STRIDE +: 8], 6'h00});
    end

    // vlan admission: active vlan always required
    // port code 3 is no switch port and is never admitted as a non-member
    s_nxt.vlan_acc = VLAN_ACTIVE & (VLAN_PORT_MEMBER |
                     (VLAN_CHECK_PORT != 2'd3 && s_r.admit[VLAN_CHECK_PORT]));

    // metering lookup, reserved mode meters nothing
    // lookup runs every cycle, so the datapath sees the entry one cycle after its inputs
    s_nxt.meter_on = s_r.mcfg[`SIP_MCFG_EN] & (mode != SIP_M_RSVD);
    s_nxt.mtr_cir  = cir_at(s_r.committed_rate_entry, meter_idx(mode, MTR_PORT, MTR_PRIO));
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  // table and limits start at their documented defaults
  // allow flags start high so no broadcast is held back before the first refill
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      s_r       <= '0;
      s_r.bcast <= `SIP_BC_RST;
      s_r.committed_rate_entry   <= {24{`SIP_CIR_RST}};
      s_r.cbs   <= `SIP_BURST_RST;
      s_r.ebs   <= `SIP_BURST_RST;
      s_r.allow <= 3'h7;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // zero wait states; error only for unmapped addresses
  // status and read data never raise an error although writes to them are dropped
  assign PREADY      = 1'b1;
  assign PSLVERR     = PSEL & PENABLE & ~hit;
  assign PRDATA      = s_r.prdata;
  assign BCAST_ALLOW = s_r.allow;
  assign VLAN_ACCEPT = s_r.vlan_acc;
  assign METER_ON    = s_r.meter_on;
  assign METER_MODE  = s_r.mcfg[`SIP_MCFG_MD_HI:`SIP_MCFG_MD_LO];
  assign MTR_CIR     = s_r.mtr_cir;
  assign MTR_CBS     = s_r.cbs;
  assign MTR_EBS     = s_r.ebs;

  // one tag-destination enable per two-bit field
  for (genvar g = 0; g < 3; g++) begin : g_tag
    assign TAG_DEST_EN[g] = &s_r.port_type[2*g +: 2];
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // all checks run on the core clock and are muted while reset is low
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  logic pend;
  assign pend = (s_r.op == SIP_BUSY);

  // register writes seen on the decoded outputs
  a_tag_dest_on: assert property (wr_acc && PADDR == waddr(`SIP_IDX_PTYPE) && PWDATA[1:0] == 2'b11
    |=> TAG_DEST_EN[0]) else $error("tag destination not enabled");
  a_tag_dest_off: assert property (wr_acc && PADDR == waddr(`SIP_IDX_PTYPE) && PWDATA[5:4] == 2'b10
    |=> !TAG_DEST_EN[2]) else $error("tag destination wrongly enabled");

  // table command timing and effect
  a_cmd_starts: assert property (cmd_wr && !pend |=> pend ##1 pend ##1 !pend)
    else $error("command length wrong");
  a_pend_bounded: assert property (pend |-> ##[1:2] !pend)
    else $error("pending never clears");
  a_rsvd_read: assert property (cmd_wr && !pend && PWDATA[7:5] == 3'b100
    |=> ##2 s_r.rdata == 16'h0000) else $error("reserved read not zero");
  a_rsvd_write: assert property (cmd_wr && !pend && PWDATA[7:5] == 3'b000
    |=> ##2 $stable(s_r.committed_rate_entry) && $stable(s_r.cbs) && $stable(s_r.ebs))
    else $error("reserved write changed table");
  a_burst_write: assert property (cmd_wr && !pend && PWDATA[7:5] == 3'b010
    |=> ##2 s_r.cbs == $past(s_r.wdata, 2)) else $error("burst write lost");

  // metering enable and lookup per mode
  a_meter_off: assert property (!s_r.mcfg[0] |=> !METER_ON)
    else $error("metering on while disabled");
  a_port_prio: assert property (s_r.mcfg[2:1] == 2'b00 && MTR_PORT == 2'd2 && MTR_PRIO[2:0] == 3'd7
    |=> MTR_CIR == $past(s_r.committed_rate_entry[23])) else $error("port and priority entry wrong");
  a_port_mode: assert property (s_r.mcfg[2:1] == 2'b01 && MTR_PORT == 2'd2
    |=> MTR_CIR == $past(s_r.committed_rate_entry[2])) else $error("port mode entry wrong");
  a_prio_mode: assert property (s_r.mcfg[2:1] == 2'b10 && MTR_PRIO == 5'd23
    |=> MTR_CIR == $past(s_r.committed_rate_entry[23])) else $error("priority mode entry wrong");

  // broadcast throttling and vlan admission
  a_throt_off: assert property (!s_r.bcast[8] && !$past(s_r.bcast[8]) |-> BCAST_ALLOW[0])
    else $error("throttle blocks while disabled");
  a_allow_fall: assert property ($fell(BCAST_ALLOW[0]) |-> $past(s_r.bcast[8]))
    else $error("allow fell on unthrottled port");
  a_throt_exhaust: assert property (s_r.bcast[8] && !tick && s_r.used[0] >= {s_r.bcast[7:0], 6'h00}
    |=> !BCAST_ALLOW[0]) else $error("broadcast budget exceeded");
  a_vlan_active: assert property (!VLAN_ACTIVE |=> !VLAN_ACCEPT)
    else $error("inactive vlan accepted");
  a_nonmember_ok: assert property (VLAN_ACTIVE && !VLAN_PORT_MEMBER && VLAN_CHECK_PORT != 2'd3 &&
    s_r.admit[VLAN_CHECK_PORT] |=> VLAN_ACCEPT) else $error("non-member not admitted");

  // main scenarios the bench should reach
  c_cir_write: cover property (cmd_wr && PWDATA[7:5] == 3'b001 ##3 !pend);
  c_cir_read: cover property (cmd_wr && PWDATA[7:5] == 3'b101 ##3 !pend);
  c_throttled: cover property (s_r.bcast[8] && !BCAST_ALLOW[0]);
  c_nonmember: cover property (VLAN_ACCEPT && !$past(VLAN_PORT_MEMBER));
  c_rsvd_mode: cover property (s_r.mcfg == 3'b111 ##1 !METER_ON);

endmodule

/* File: test_switch_ingress_policy_regs.sv */
// Purpose: self-checking bench for the ingress policy register bank
// Assumes: zero-wait apb slave, two-cycle table commands
// Notes:   short broadcast interval set by parameter to keep the run brief
`timescale 1ns/1ps
`include "sip_consts.svh"
module test_switch_ingress_policy_regs;
  import sip_pkg::*;
  localparam int TCYC = 400;
  typedef struct {logic [13:0] idx; logic [31:0] wd; logic [31:0] exp;} sip_row_t;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  bcast_byte = 3'h0;
  logic [1:0]  vl_port = 2'h0;
  logic        vl_mem = 1'b0;
  logic        vl_act = 1'b0;
  logic [1:0]  mtr_port = 2'h0;
  logic [4:0]  mtr_prio = 5'h00;
  logic [31:0] PRDATA, rd_q;
  logic        PREADY, PSLVERR, err_q, VLAN_ACCEPT, METER_ON;
  logic [2:0]  TAG_DEST_EN, BCAST_ALLOW;
  logic [1:0]  METER_MODE;
  logic [15:0] MTR_CIR, MTR_CBS, MTR_EBS;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cnt;
  sip_row_t    rows [7] = '{
    '{`SIP_IDX_PTYPE, 32'hffffffff, 32'h0000003f}, '{`SIP_IDX_PTYPE, 32'h00000036, 32'h00000036},
    '{`SIP_IDX_BCAST, 32'hffffffff, 32'h07ffffff}, '{`SIP_IDX_ADMIT, 32'hffffffff, 32'h00000007},
    '{`SIP_IDX_MCFG, 32'hffffffff, 32'h00000007}, '{`SIP_IDX_WDATA, 32'hffffffff, 32'h0000ffff},
    '{`SIP_IDX_STS, 32'hffffffff, 32'h00000000}};

  sip_regs #(.THROT_CYC(TCYC)) dut (.CORE_CLK(core_clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TAG_DEST_EN(TAG_DEST_EN), .BCAST_BYTE(bcast_byte), .BCAST_ALLOW(BCAST_ALLOW),
    .VLAN_CHECK_PORT(vl_port), .VLAN_PORT_MEMBER(vl_mem), .VLAN_ACTIVE(vl_act), .VLAN_ACCEPT(VLAN_ACCEPT),
    .MTR_PORT(mtr_port), .MTR_PRIO(mtr_prio), .METER_ON(METER_ON), .METER_MODE(METER_MODE),
    .MTR_CIR(MTR_CIR), .MTR_CBS(MTR_CBS), .MTR_EBS(MTR_EBS));

  // free-running core clock, 10 ns period
  always #5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // apb master: request held until pready seen high at a rising edge
  task automatic apb(input logic w, input logic [13:0] idx, input logic [31:0] wd);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge core_clk);
      if (PREADY === 1'b1) break;
    end
    if (k == 16) begin
      chk(1'b0, 1'b1, "pready timeout");
      tally_and_finish();
    end
    rd_q = PRDATA;
    err_q = PSLVERR;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [13:0] idx, input logic [31:0] exp, input string what);
    apb(1'b0, idx, 32'h0);
    chk(rd_q, exp, what);
  endtask

  // one table command, then poll pending with a bounded count
  task automatic tbl(input logic [7:0] c);
    int k;
    apb(1'b1, `SIP_IDX_CMD, {24'h0, c});
    rdc(`SIP_IDX_STS, 32'h1, "pending set");
    for (k = 0; k < 8; k++) begin
      apb(1'b0, `SIP_IDX_STS, 32'h0);
      if (rd_q === 32'h0) break;
    end
    chk(k < 8, 1'b1, "pending cleared");
    if (k == 8) tally_and_finish();
  endtask

  task automatic look(input logic [1:0] p, input logic [4:0] pr, input logic [15:0] exp);
    @(posedge core_clk);
    mtr_port <= p;
    mtr_prio <= pr;
    repeat (2) @(negedge core_clk);
    chk(MTR_CIR, exp, "rate lookup");
  endtask

  task automatic vl(input logic [1:0] p, input logic m, input logic a, input logic exp);
    @(posedge core_clk);
    vl_port <= p;
    vl_mem <= m;
    vl_act <= a;
    repeat (2) @(negedge core_clk);
    chk(VLAN_ACCEPT, exp, "vlan accept");
  endtask

  // wait for port 0 allow to reach a level, bounded
  task automatic wait_allow(input logic v);
    int k;
    for (k = 0; k < 500 && BCAST_ALLOW[0] !== v; k++) @(negedge core_clk);
    if (k == 500) begin
      chk(1'b0, 1'b1, "allow timeout");
      tally_and_finish();
    end
  endtask

  task automatic do_reset();
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence: reset values, row loop, then hand-written cases
  initial begin
    do_reset();
    rdc(`SIP_IDX_BCAST, 32'h00080402, "bcast reset");
    rdc(`SIP_IDX_CMD, 32'h0, "cmd reset");
    chk(MTR_CBS, `SIP_BURST_RST, "cbs reset");
    chk(MTR_EBS, `SIP_BURST_RST, "ebs reset");
    for (int i = 0; i < 7; i++) begin
      apb(1'b1, rows[i].idx, rows[i].wd);
      rdc(rows[i].idx, rows[i].exp, "readback");
    end
    chk(TAG_DEST_EN, 3'b100, "tag dest");
    apb(1'b1, `SIP_IDX_PTYPE, 32'h0000000f);
    repeat (2) @(negedge core_clk);
    chk(TAG_DEST_EN, 3'b011, "tag dest");
    apb(1'b0, 14'h1850, 32'h0);
    chk({31'h0, err_q}, 32'h1, "unmapped error");
    chk(rd_q, 32'h0, "unmapped read");
    // table: reset entries, write then read, reserved type
    tbl(8'ha5);
    rdc(`SIP_IDX_RDATA, 32'h0014, "cir reset");
    tbl(8'hc0);
    rdc(`SIP_IDX_RDATA, 32'h0600, "cbs read");
    apb(1'b1, `SIP_IDX_WDATA, 32'h1234);
    tbl(8'h37);
    tbl(8'hb7);
    rdc(`SIP_IDX_RDATA, 32'h1234, "cir 23");
    rdc(`SIP_IDX_CMD, 32'hb7, "cmd fields");
    apb(1'b1, `SIP_IDX_WDATA, 32'h0111);
    tbl(8'h28);
    apb(1'b1, `SIP_IDX_WDATA, 32'h0222);
    tbl(8'h21);
    tbl(8'h00);
    chk({MTR_CBS, MTR_EBS}, 32'h06000600, "reserved write");
    tbl(8'h80);
    rdc(`SIP_IDX_RDATA, 32'h0, "reserved read");
    apb(1'b1, `SIP_IDX_WDATA, 32'h0abc);
    tbl(8'h40);
    apb(1'b1, `SIP_IDX_WDATA, 32'h0def);
    tbl(8'h60);
    chk({MTR_CBS, MTR_EBS}, 32'h0abc0def, "burst write");
    // metering modes and lookup
    apb(1'b1, `SIP_IDX_MCFG, 32'h1);
    repeat (2) @(negedge core_clk);
    chk({METER_ON, METER_MODE}, 3'b100, "meter on");
    look(2'd2, 5'd7, 16'h1234);
    look(2'd1, 5'd0, 16'h0111);
    look(2'd0, 5'd0, 16'h0014);
    apb(1'b1, `SIP_IDX_MCFG, 32'h3);
    look(2'd1, 5'd7, 16'h0222);
    look(2'd2, 5'd0, 16'h0014);
    apb(1'b1, `SIP_IDX_MCFG, 32'h5);
    look(2'd0, 5'd23, 16'h1234);
    look(2'd2, 5'd8, 16'h0111);
    apb(1'b1, `SIP_IDX_MCFG, 32'h7);
    repeat (2) @(negedge core_clk);
    chk(METER_ON, 1'b0, "reserved mode");
    apb(1'b1, `SIP_IDX_MCFG, 32'h4);
    repeat (2) @(negedge core_clk);
    chk({METER_ON, METER_MODE}, 3'b010, "meter off");
    // non-member admission needs an active vlan
    apb(1'b1, `SIP_IDX_ADMIT, 32'h2);
    vl(2'd1, 1'b0, 1'b1, 1'b1);
    vl(2'd1, 1'b0, 1'b0, 1'b0);
    vl(2'd0, 1'b0, 1'b1, 1'b0);
    vl(2'd2, 1'b1, 1'b1, 1'b1);
    // port 0 throttled at 64 bytes, port 1 unthrottled
    apb(1'b1, `SIP_IDX_BCAST, 32'h00000101);
    @(posedge core_clk);
    bcast_byte <= 3'b011;
    wait_allow(1'b0);
    wait_allow(1'b1);
    for (cnt = 0; cnt < 500 && BCAST_ALLOW[0] === 1'b1; cnt++) @(negedge core_clk);
    chk(cnt == 64 || cnt == 65, 1'b1, "bcast budget");
    if (cnt == 500) tally_and_finish();
    chk(BCAST_ALLOW[1], 1'b1, "bcast off");
    @(posedge core_clk);
    bcast_byte <= 3'b000;
    // second reset mid-run
    do_reset();
    rdc(`SIP_IDX_MCFG, 32'h0, "mcfg reset");
    chk(MTR_CBS, `SIP_BURST_RST, "cbs reset");
    tally_and_finish();
  end
endmodule
